//--- hw/rmfl_consts.vh
// rmfl_consts.vh - register map, field positions and reset values of the
// reference monitor failure latch and mask bank.
// assumes: included by bare name from the rmfl design files.
`ifndef RMFL_CONSTS_VH
`define RMFL_CONSTS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define RMFL_ADDR_W              8
`define RMFL_OFS_ISR_STATUS      8'h02
`define RMFL_OFS_FLAGS_HIGH      8'h06
`define RMFL_OFS_FLAGS_LOW       8'h07
`define RMFL_OFS_MASK_HIGH       8'h08
`define RMFL_OFS_MASK_LOW        8'h09

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RMFL_FLAGS_RESET         8'h00
`define RMFL_MASK_RESET          8'h66
`define RMFL_RDATA_UNMAPPED      8'h00

// ----------------------------------------------------------------------
// cause positions inside one four-bit nibble
// ----------------------------------------------------------------------
`define RMFL_CAUSE_W             4
`define RMFL_BIT_LOSS            0
`define RMFL_BIT_SINGLE          1
`define RMFL_BIT_FREQ            2
`define RMFL_BIT_GUARD           3

// ----------------------------------------------------------------------
// field positions inside an eight-bit register
// ----------------------------------------------------------------------
`define RMFL_LO_NIB_LSB          0
`define RMFL_HI_NIB_LSB          4

`endif

//--- hw/rmfl_ref_flags.v
// rmfl_ref_flags.v - four sticky failure indicators of one reference plus
// the masked copy of its causes for the interrupt status register.
// assumes: all inputs synchronous to clock; host clears by write-one.
`timescale 1ns/1ps
`default_nettype none
`include "rmfl_consts.vh"

module rmfl_ref_flags #(
    parameter GPIO_N = 16,
    parameter SEL_W  = 4
) (
    input  wire              clock,
    input  wire              rst,
    input  wire [GPIO_N-1:0] gpio_in,
    input  wire [SEL_W-1:0]  loss_sel,
    input  wire              single_fail,
    input  wire              coarse_fail,
    input  wire              precise_fail,
    input  wire              guard_expire,
    input  wire [3:0]        cause_enable,
    input  wire              clear_wr,
    input  wire [3:0]        clear_bits,
    output reg  [3:0]        flags_r,
    output reg  [3:0]        isr_r
);

    // ------------------------------------------------------------------
    // cause collection
    // ------------------------------------------------------------------
    wire       loss_in;
    wire [3:0] cause;
    wire [3:0] clr;
    reg  [3:0] flags_nxt;
    reg  [3:0] isr_nxt;

    // loss of signal comes from whichever gpio the function config routes
    assign loss_in = gpio_in[loss_sel];
    assign cause[`RMFL_BIT_LOSS]   = loss_in;
    assign cause[`RMFL_BIT_SINGLE] = single_fail;
    assign cause[`RMFL_BIT_FREQ]   = coarse_fail | precise_fail;
    assign cause[`RMFL_BIT_GUARD]  = guard_expire;
    assign clr = clear_wr ? clear_bits : 4'h0;

    // ------------------------------------------------------------------
    // sticky bits: no mask term here, and a new event beats a clear
    // ------------------------------------------------------------------
    always @* begin
        flags_nxt = (flags_r & ~clr) | cause;
        // each cause obeys its mask bit, except precise frequency, which stays visible
        isr_nxt[`RMFL_BIT_LOSS]   = cause[`RMFL_BIT_LOSS]   & cause_enable[`RMFL_BIT_LOSS];
        isr_nxt[`RMFL_BIT_SINGLE] = cause[`RMFL_BIT_SINGLE] & cause_enable[`RMFL_BIT_SINGLE];
        isr_nxt[`RMFL_BIT_FREQ]   = (coarse_fail & cause_enable[`RMFL_BIT_FREQ])
                                    | precise_fail;
        isr_nxt[`RMFL_BIT_GUARD]  = cause[`RMFL_BIT_GUARD]  & cause_enable[`RMFL_BIT_GUARD];
    end

    always @(posedge clock) begin
        if (rst) begin
            flags_r <= 4'h0;
            isr_r   <= 4'h0;
        end else begin
            flags_r <= flags_nxt;
            isr_r   <= isr_nxt;
        end
    end

endmodule // rmfl_ref_flags
`default_nettype wire

//--- hw/rmfl_mask_reg.v
// rmfl_mask_reg.v - one eight-bit read/write mask register, two nibbles.
// assumes: write strobe is a one-cycle pulse already decoded for this reg.
`timescale 1ns/1ps
`default_nettype none
`include "rmfl_consts.vh"

module rmfl_mask_reg #(
    parameter [7:0] RESET_VAL = `RMFL_MASK_RESET
) (
    input  wire       clock,
    input  wire       rst,
    input  wire       wr,
    input  wire [7:0] wdata,
    output reg  [7:0] value_r
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            value_r <= RESET_VAL;
        end else if (wr) begin
            value_r <= wdata;
        end
    end

endmodule // rmfl_mask_reg
`default_nettype wire

//--- hw/rmfl_bank.v
// rmfl_bank.v - reference monitor failure latch and mask register bank.
// assumes: monitor pulses and gpio levels are synchronous to clock; the
// host port gives one-cycle read and write strobes with a byte address.
//
// Summary of operation
// - reference 0 signal-loss flag, bit 0 of 0x07, set when routed gpio high
// - each reference's signal-loss input selectable from any gpio pin
// - reference 0 single-cycle flag, bit 1, set on single-cycle failure
// - reference 0 frequency flag, bit 2, set on coarse or precise failure
// - reference 0 guard-soak flag, bit 3, set when guard soak timer expires
// - no mask ever suppresses the sticky indicator bits
// - reference 1 indicators sit in bits 7:4 of 0x07, same order
// - 0x08 holds reference 2 mask in 3:0 and reference 3 mask in 7:4
// - mask nibble: bit0 loss, bit1 single cycle, bit2 coarse, bit3 guard
// - mask bit 0 disables its cause, 1 enables it
// - cleared mask bit hides its cause from status register 0x02
// - sticky bits of 0x06 are untouched by any mask
// - references 2 and 3 indicators live in 0x06, same layout as 0x07
// - 0x09 holds reference 0 and 1 masks, same layout, default 0x66
`timescale 1ns/1ps
`default_nettype none
`include "rmfl_consts.vh"

module rmfl_bank #(
    parameter GPIO_N = 16,
    parameter SEL_W  = 4
) (
    input  wire                    clock,
    input  wire                    rst,
    // host register port
    input  wire [`RMFL_ADDR_W-1:0] reg_addr,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    input  wire [7:0]              reg_wdata,
    output reg  [7:0]              reg_rdata_r,
    output reg                     reg_rvalid_r,
    // external levels and gpio routing
    input  wire [GPIO_N-1:0]       gpio_in,
    input  wire [SEL_W-1:0]        ref0_loss_sel,
    input  wire [SEL_W-1:0]        ref1_loss_sel,
    input  wire [SEL_W-1:0]        ref2_loss_sel,
    input  wire [SEL_W-1:0]        ref3_loss_sel,
    // monitor events, one bit per reference
    input  wire [3:0]              single_fail,
    input  wire [3:0]              coarse_fail,
    input  wire [3:0]              precise_fail,
    input  wire [3:0]              guard_expire,
    // masked causes towards the interrupt status register
    output reg  [15:0]             isr_cause_r,
    // sticky registers, also visible as ports
    output reg  [7:0]              flags_low_r,
    output reg  [7:0]              flags_high_r
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    reg  wr_flags_low;
    reg  wr_flags_high;
    reg  wr_mask_high;
    reg  wr_mask_low;

    always @* begin
        wr_flags_low  = 1'b0;
        wr_flags_high = 1'b0;
        wr_mask_high  = 1'b0;
        wr_mask_low   = 1'b0;
        if (reg_wr && reg_addr == `RMFL_OFS_FLAGS_LOW) begin
            wr_flags_low = 1'b1;
        end else if (reg_wr && reg_addr == `RMFL_OFS_FLAGS_HIGH) begin
            wr_flags_high = 1'b1;
        end else if (reg_wr && reg_addr == `RMFL_OFS_MASK_HIGH) begin
            wr_mask_high = 1'b1;
        end else if (reg_wr && reg_addr == `RMFL_OFS_MASK_LOW) begin
            wr_mask_low = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // mask registers
    // ------------------------------------------------------------------
    wire [7:0] mask_high;
    wire [7:0] mask_low;

    rmfl_mask_reg #(
        .RESET_VAL (`RMFL_MASK_RESET)
    ) u_mask_high (
        .clock   (clock),
        .rst     (rst),
        .wr      (wr_mask_high),
        .wdata   (reg_wdata),
        .value_r (mask_high)
    );

    rmfl_mask_reg #(
        .RESET_VAL (`RMFL_MASK_RESET)
    ) u_mask_low (
        .clock   (clock),
        .rst     (rst),
        .wr      (wr_mask_low),
        .wdata   (reg_wdata),
        .value_r (mask_low)
    );

    // nibble split: a 1 enables the cause towards the status register
    wire [3:0] ref0_cause_enable = mask_low[`RMFL_LO_NIB_LSB +: `RMFL_CAUSE_W];
    wire [3:0] ref1_cause_enable = mask_low[`RMFL_HI_NIB_LSB +: `RMFL_CAUSE_W];
    wire [3:0] ref2_cause_enable = mask_high[`RMFL_LO_NIB_LSB +: `RMFL_CAUSE_W];
    wire [3:0] ref3_cause_enable = mask_high[`RMFL_HI_NIB_LSB +: `RMFL_CAUSE_W];

    // ------------------------------------------------------------------
    // per-reference sticky flags
    // ------------------------------------------------------------------
    wire [3:0] ref0_flags;
    wire [3:0] ref1_flags;
    wire [3:0] ref2_flags;
    wire [3:0] ref3_flags;
    wire [3:0] ref0_isr;
    wire [3:0] ref1_isr;
    wire [3:0] ref2_isr;
    wire [3:0] ref3_isr;

    rmfl_ref_flags #(.GPIO_N(GPIO_N), .SEL_W(SEL_W)) u_ref0 (
        .clock        (clock),
        .rst          (rst),
        .gpio_in      (gpio_in),
        .loss_sel     (ref0_loss_sel),
        .single_fail  (single_fail[0]),
        .coarse_fail  (coarse_fail[0]),
        .precise_fail (precise_fail[0]),
        .guard_expire (guard_expire[0]),
        .cause_enable (ref0_cause_enable),
        .clear_wr     (wr_flags_low),
        .clear_bits   (reg_wdata[`RMFL_LO_NIB_LSB +: `RMFL_CAUSE_W]),
        .flags_r      (ref0_flags),
        .isr_r        (ref0_isr)
    );

    rmfl_ref_flags #(.GPIO_N(GPIO_N), .SEL_W(SEL_W)) u_ref1 (
        .clock        (clock),
        .rst          (rst),
        .gpio_in      (gpio_in),
        .loss_sel     (ref1_loss_sel),
        .single_fail  (single_fail[1]),
        .coarse_fail  (coarse_fail[1]),
        .precise_fail (precise_fail[1]),
        .guard_expire (guard_expire[1]),
        .cause_enable (ref1_cause_enable),
        .clear_wr     (wr_flags_low),
        .clear_bits   (reg_wdata[`RMFL_HI_NIB_LSB +: `RMFL_CAUSE_W]),
        .flags_r      (ref1_flags),
        .isr_r        (ref1_isr)
    );

    rmfl_ref_flags #(.GPIO_N(GPIO_N), .SEL_W(SEL_W)) u_ref2 (
        .clock        (clock),
        .rst          (rst),
        .gpio_in      (gpio_in),
        .loss_sel     (ref2_loss_sel),
        .single_fail  (single_fail[2]),
        .coarse_fail  (coarse_fail[2]),
        .precise_fail (precise_fail[2]),
        .guard_expire (guard_expire[2]),
        .cause_enable (ref2_cause_enable),
        .clear_wr     (wr_flags_high),
        .clear_bits   (reg_wdata[`RMFL_LO_NIB_LSB +: `RMFL_CAUSE_W]),
        .flags_r      (ref2_flags),
        .isr_r        (ref2_isr)
    );

    rmfl_ref_flags #(.GPIO_N(GPIO_N), .SEL_W(SEL_W)) u_ref3 (
        .clock        (clock),
        .rst          (rst),
        .gpio_in      (gpio_in),
        .loss_sel     (ref3_loss_sel),
        .single_fail  (single_fail[3]),
        .coarse_fail  (coarse_fail[3]),
        .precise_fail (precise_fail[3]),
        .guard_expire (guard_expire[3]),
        .cause_enable (ref3_cause_enable),
        .clear_wr     (wr_flags_high),
        .clear_bits   (reg_wdata[`RMFL_HI_NIB_LSB +: `RMFL_CAUSE_W]),
        .flags_r      (ref3_flags),
        .isr_r        (ref3_isr)
    );

    // ------------------------------------------------------------------
    // register images: sticky words carry no mask term at all
    // ------------------------------------------------------------------
    wire [7:0] flags_low_img  = {ref1_flags, ref0_flags};
    wire [7:0] flags_high_img = {ref3_flags, ref2_flags};

    // ------------------------------------------------------------------
    // read port: data one cycle after the strobe; reads never clear
    // ------------------------------------------------------------------
    reg [7:0] rdata_nxt;

    always @* begin
        if (reg_addr == `RMFL_OFS_FLAGS_LOW) begin
            rdata_nxt = flags_low_img;
        end else if (reg_addr == `RMFL_OFS_FLAGS_HIGH) begin
            rdata_nxt = flags_high_img;
        end else if (reg_addr == `RMFL_OFS_MASK_HIGH) begin
            rdata_nxt = mask_high;
        end else if (reg_addr == `RMFL_OFS_MASK_LOW) begin
            rdata_nxt = mask_low;
        end else begin
            rdata_nxt = `RMFL_RDATA_UNMAPPED;
        end
    end

    always @(posedge clock) begin
        if (rst) begin
            reg_rdata_r  <= 8'h00;
            reg_rvalid_r <= 1'b0;
            isr_cause_r  <= 16'h0000;
            flags_low_r  <= `RMFL_FLAGS_RESET;
            flags_high_r <= `RMFL_FLAGS_RESET;
        end else begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= rdata_nxt;
            end
            // status copy follows the masked causes; the sticky ports do not
            isr_cause_r  <= {ref3_isr, ref2_isr, ref1_isr, ref0_isr};
            flags_low_r  <= flags_low_img;
            flags_high_r <= flags_high_img;
        end
    end

endmodule // rmfl_bank
`default_nettype wire

//--- tb/rmfl_bank_checker.sv
// rmfl_bank_checker.sv - port level assertions for the failure latch bank.
// assumes: bound into rmfl_bank; masks are shadowed from host writes.
`timescale 1ns/1ps
`default_nettype none
module rmfl_bank_checker #(
    parameter GPIO_N = 16,
    parameter SEL_W  = 4
) (
    input wire logic              clock,
    input wire logic              rst,
    input wire logic [7:0]        reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_wdata,
    input wire logic [7:0]        reg_rdata_r,
    input wire logic [GPIO_N-1:0] gpio_in,
    input wire logic [SEL_W-1:0]  ref0_loss_sel,
    input wire logic [3:0]        single_fail,
    input wire logic [3:0]        coarse_fail,
    input wire logic [3:0]        precise_fail,
    input wire logic [3:0]        guard_expire,
    input wire logic [15:0]       isr_cause_r,
    input wire logic [7:0]        flags_low_r,
    input wire logic [7:0]        flags_high_r
);
    // masks are not visible at the ports, so they are rebuilt here
    logic [15:0] mask_r;
    wire         wr07 = reg_wr && reg_addr == 8'h07;
    wire  [7:0]  mask_hi = mask_r[15:8];
    always_ff @(posedge clock) begin
        if (rst)
            mask_r <= 16'h6666;
        else if (reg_wr && reg_addr == 8'h08)
            mask_r[15:8] <= reg_wdata;
        else if (reg_wr && reg_addr == 8'h09)
            mask_r[7:0] <= reg_wdata;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_loss_sets: assert property (gpio_in[ref0_loss_sel] |-> ##2 flags_low_r[0])
        else $error("loss level did not set its flag");
    a_single_sets: assert property (single_fail[0] |-> ##2 flags_low_r[1])
        else $error("single cycle failure not latched");
    a_freq_sets: assert property (coarse_fail[0] || precise_fail[0] |-> ##2 flags_low_r[2])
        else $error("frequency failure not latched");
    a_guard_sets: assert property (guard_expire[0] |-> ##2 flags_low_r[3])
        else $error("guard soak expiry not latched");
    a_ref1_order: assert property (single_fail[1] |-> ##2 flags_low_r[5])
        else $error("reference 1 single cycle flag misplaced");
    a_high_flags: assert property (coarse_fail[3] || precise_fail[3] |-> ##2 flags_high_r[6])
        else $error("reference 3 frequency flag misplaced");
    a_sticky_hold: assert property (!$past(rst) && |($past(flags_low_r) & ~flags_low_r) |-> $past(wr07, 2))
        else $error("sticky flag fell without a clear");
    a_isr_masked: assert property ((isr_cause_r & ~$past(mask_r, 2) & 16'hbbbb) == 16'h0000)
        else $error("masked cause reached status feed");
    a_isr_enable: assert property (single_fail[0] && mask_r[1] |-> ##2 isr_cause_r[1])
        else $error("enabled cause missing from status feed");
    a_read_flags: assert property (reg_rd && reg_addr == 8'h07 |=> reg_rdata_r == flags_low_r)
        else $error("flag register read mismatch");
    a_read_mask: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata_r == $past(mask_hi))
        else $error("mask register read mismatch");
    c_clear: cover property (wr07 ##1 flags_low_r != 8'h00);
    c_isr_hit: cover property (isr_cause_r != 16'h0000);
    c_high_loss: cover property (flags_high_r[0]);
endmodule // rmfl_bank_checker
`default_nettype wire

//--- tb/rmfl_phy_model.sv
// rmfl_phy_model.sv - far side device driving loss-of-signal levels on gpios.
// assumes: loss changes on the falling edge; sel holds four pin indices.
`timescale 1ns/1ps
`default_nettype none
module rmfl_phy_model #(
    parameter GPIO_N = 16
) (
    input  wire logic              clock,
    input  wire logic [3:0]        loss,
    input  wire logic [15:0]       sel,
    output logic      [GPIO_N-1:0] gpio
);
    // unrouted pins toggle so a stale idle level never passes for a match
    logic [GPIO_N-1:0] noise_r = '0;
    always @(negedge clock)
        noise_r <= ~noise_r;
    always_comb begin
        gpio = noise_r;
        for (int k = 0; k < 4; k++)
            gpio[sel[k*4 +: 4]] = loss[k];
    end
endmodule // rmfl_phy_model
`default_nettype wire

//--- tb/tb_top.sv
// tb_top.sv - self-checking bench for the failure latch and mask bank.
// assumes: design files under hw/ with rmfl_consts.vh on the include path.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [3:0]  loss = 4'h0;
    logic [15:0] sel = 16'hc840;
    logic [3:0]  sgl = 4'h0;
    logic [3:0]  crs = 4'h0;
    logic [3:0]  prc = 4'h0;
    logic [3:0]  gst = 4'h0;
    wire  [15:0] gpio;
    wire  [7:0]  rdata;
    wire         rvalid;
    wire  [15:0] isr;
    wire  [7:0]  fl;
    wire  [7:0]  fh;
    int          fails = 0;
    int          checks_done = 0;
    logic [7:0]  exp_q[$];
    logic [15:0] mask;
    logic [7:0]  ra;
    int          n;
    int          c;
    logic        prec;

    rmfl_phy_model #(.GPIO_N(16)) phy_u (.clock(clock), .loss(loss), .sel(sel), .gpio(gpio));
    rmfl_bank #(.GPIO_N(16), .SEL_W(4)) dut_u (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata_r(rdata), .reg_rvalid_r(rvalid), .gpio_in(gpio),
        .ref0_loss_sel(sel[3:0]), .ref1_loss_sel(sel[7:4]), .ref2_loss_sel(sel[11:8]),
        .ref3_loss_sel(sel[15:12]), .single_fail(sgl), .coarse_fail(crs), .precise_fail(prc),
        .guard_expire(gst), .isr_cause_r(isr), .flags_low_r(fl), .flags_high_r(fh));

    initial
        forever #5 clock = ~clock;

    task automatic chk(input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        reg_rd = 1'b1;
        reg_addr = a;
        exp_q.push_back(e);
        @(negedge clock);
        reg_rd = 1'b0;
    endtask

    task automatic end_of_test();
        if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // read answers are matched in issue order against the noted values
    always @(posedge clock)
        if (rvalid === 1'b1)
            chk({8'h00, exp_q.pop_front()}, {8'h00, rdata});

    initial begin
        #100000;
        fails++;
        end_of_test();
    end

    initial begin
        n = $urandom(87197);
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        rd(8'h07, 8'h00);
        rd(8'h06, 8'h00);
        rd(8'h08, 8'h66);
        rd(8'h09, 8'h66);
        rd(8'h0b, 8'h00);
        for (int i = 0; i < 32; i++) begin
            n = i % 4;
            c = (i / 4) % 4;
            prec = 1'($urandom);
            mask = 16'($urandom);
            ra = n < 2 ? 8'h07 : 8'h06;
            sel = 16'hc840 | 16'($urandom & 16'h3333);
            wr(8'h08, mask[15:8]);
            wr(8'h09, mask[7:0]);
            rd(8'h08, mask[15:8]);
            @(negedge clock);
            loss = 4'(c == 0) << n;
            sgl = 4'(c == 1) << n;
            crs = 4'(c == 2 && !prec) << n;
            prc = 4'(c == 2 && prec) << n;
            gst = 4'(c == 3) << n;
            @(negedge clock);
            {loss, sgl, crs, prc, gst} = '0;
            // status feed and sticky copies are two register stages behind the event
            @(negedge clock);
            // a precise failure passes even with the coarse enable cleared
            chk(16'(mask[n*4+c] | (c == 2 && prec)) << (n * 4 + c), isr);
            chk(16'h0001 << (n * 4 + c), {fh, fl});
            rd(ra, 8'h01 << (n % 2 * 4 + c));
            wr(ra, 8'hff);
            rd(ra, 8'h00);
            rd(8'h09, mask[7:0]);
        end
        @(negedge clock);
        rst = 1'b1;
        @(negedge clock);
        rst = 1'b0;
        rd(8'h08, 8'h66);
        repeat (3) @(negedge clock);
        chk(16'h0000, 16'(exp_q.size()));
        end_of_test();
    end
endmodule // tb_top

bind rmfl_bank rmfl_bank_checker #(.GPIO_N(GPIO_N), .SEL_W(SEL_W)) chk_u (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .gpio_in(gpio_in),
    .ref0_loss_sel(ref0_loss_sel), .single_fail(single_fail), .coarse_fail(coarse_fail),
    .precise_fail(precise_fail), .guard_expire(guard_expire), .isr_cause_r(isr_cause_r),
    .flags_low_r(flags_low_r), .flags_high_r(flags_high_r));
`default_nettype wire
